// File: ccs_clock_select.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"
// How it works
// RULE_01: straps latched during reset, held until reset
// RULE_02: strap code selects cpu clock factor
// RULE_03: code 001 halves the input clock
// RULE_04: code 011 drives cpu directly, loop off (the loop runs here while the watchdog is enabled)
// RULE_05: other codes run multiplier at factor
// RULE_06: multiplier resyncs every F input transitions
// RULE_07: watchdog supervises direct and prescaled modes
// RULE_08: watchdog on after reset, bit 4 disables
// RULE_09: enabled watchdog counts free-running loop cycles
// RULE_10: every input transition clears watchdog counter
// RULE_11: sixteen loop cycles without transition means failure
// RULE_12: failure switches to loop clock, sets flag
// RULE_13: fallback sticks until hardware reset
// RULE_14: watchdog disabled keeps input clock, loop off
// RULE_15: input transitions synchronised before clearing counter
// RULE_16: source switch without glitches or short pulses
module ccs_clock_select #(
   parameter int PERIOD_W = 16,
   parameter int LOOP_DIV = `CCS_LOOP_DIV
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        clock_input_pin,
   input  wire logic [2:0]  clock_mode_strap_pins,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cpu_clk,
   output logic             loop_enable,
   output logic             cpu_on_loop,
   output logic             clock_fail_irq
);

   // ============================================================
   // pin synchronisers
   logic       xin_s1_r;
   logic       xin_s2_r;
   logic       xin_s3_r;
   logic [2:0] strap_s1_r;
   logic [2:0] strap_s2_r;

   // no reset: they must keep sampling while srst is held
   always_ff @(posedge clk_sys) begin
      xin_s1_r   <= clock_input_pin;
      xin_s2_r   <= xin_s1_r;
      xin_s3_r   <= xin_s2_r;
      strap_s1_r <= clock_mode_strap_pins;
      strap_s2_r <= strap_s1_r;
   end

   logic xin_edge;
   logic xin_rise;
   assign xin_edge = xin_s2_r ^ xin_s3_r;        // [RULE_15]
   assign xin_rise = xin_s2_r & ~xin_s3_r;

   // ============================================================
   // strap latch
   logic [2:0] mode_r;

   // follows the straps while reset is held, frozen after release
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_r <= strap_s2_r;                   // [RULE_01]
      end
   end

   ccs_pkg::ccs_path_t path;
   always_comb begin
      if (mode_r == `CCS_CODE_PRESCALE) begin
         path = ccs_pkg::CCS_PATH_PRESCALE;
      end else if (mode_r == `CCS_CODE_DIRECT) begin
         path = ccs_pkg::CCS_PATH_DIRECT;
      end else begin
         path = ccs_pkg::CCS_PATH_MULT;
      end
   end

   // toggles per input period (2F) and transitions between resyncs
   logic [3:0] toggles_per_period;
   logic [3:0] resync_trans;
   always_comb begin
      case (mode_r)                              // [RULE_02]
         3'h7: begin toggles_per_period = 4'h8; resync_trans = 4'h4; end
         3'h6: begin toggles_per_period = 4'h6; resync_trans = 4'h3; end
         3'h5: begin toggles_per_period = 4'h4; resync_trans = 4'h2; end
         3'h4: begin toggles_per_period = 4'hA; resync_trans = 4'h5; end
         3'h2: begin toggles_per_period = 4'h3; resync_trans = 4'h2; end
         3'h0: begin toggles_per_period = 4'h5; resync_trans = 4'h3; end
         default: begin toggles_per_period = 4'h2; resync_trans = 4'h1; end
      endcase
   end

   // ============================================================
   // register file
   logic owd_dis_r;
   logic irq_r;
   logic fail_r;
   logic wr_en;
   logic rd_setup;
   logic hit;

   assign hit      = (paddr == `CCS_OFS_SYSCFG) || (paddr == `CCS_OFS_STATUS);
   assign wr_en    = psel & penable & pwrite & hit;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~hit;

   // watchdog disable bit steers the loop and supervision
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         owd_dis_r <= `CCS_SYSCFG_RST;           // [RULE_08]
      end else if (wr_en && paddr == `CCS_OFS_SYSCFG) begin
         owd_dis_r <= pwdata[`CCS_SYSCFG_OWD_DIS];
      end
   end

   // read data captured in setup so it sits in a flop at access
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         if (paddr == `CCS_OFS_SYSCFG) begin
            prdata[`CCS_SYSCFG_OWD_DIS] <= owd_dis_r;
         end else if (paddr == `CCS_OFS_STATUS) begin
            prdata[`CCS_STAT_MODE_HI:`CCS_STAT_MODE_LO] <= mode_r;
            prdata[`CCS_STAT_FAIL]    <= fail_r;
            prdata[`CCS_STAT_IRQ]     <= irq_r;
            prdata[`CCS_STAT_LOOP_EN] <= loop_enable;
         end
      end
   end

   // ============================================================
   // free-running loop and watchdog
   logic       supervised;
   logic       loop_tick;
   logic [7:0] loop_div_r;
   logic [3:0] owd_cnt_r;
   logic       owd_overflow;

   // direct or prescaled drive is supervised only with the watchdog on
   assign supervised = (path != ccs_pkg::CCS_PATH_MULT) & ~owd_dis_r;   // [RULE_07]
   // loop stays up once fallen back, since it then clocks the cpu
   assign loop_enable = (path == ccs_pkg::CCS_PATH_MULT) | supervised
                        | fail_r;                // [RULE_05] [RULE_14] [RULE_04]

   // divider standing in for the loop free-running frequency
   always_ff @(posedge clk_sys) begin
      if (srst || !loop_enable) begin
         loop_div_r <= 8'h00;
      end else if (loop_div_r == 8'(LOOP_DIV - 1)) begin
         loop_div_r <= 8'h00;
      end else begin
         loop_div_r <= loop_div_r + 8'h01;
      end
   end
   assign loop_tick = loop_enable && (loop_div_r == 8'(LOOP_DIV - 1));

   assign owd_overflow = supervised & ~fail_r & loop_tick & ~xin_edge
                         & (owd_cnt_r == `CCS_OWD_LIMIT);    // [RULE_11]

   // counter clear wins over an increment in the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst || !supervised) begin
         owd_cnt_r <= 4'h0;
      end else if (xin_edge) begin
         owd_cnt_r <= 4'h0;                      // [RULE_10]
      end else if (loop_tick && owd_cnt_r != `CCS_OWD_LIMIT) begin
         owd_cnt_r <= owd_cnt_r + 4'h1;          // [RULE_09]
      end
   end

   // failure is sticky; only reset brings the input back
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fail_r <= 1'b0;
      end else if (owd_overflow) begin
         fail_r <= 1'b1;                         // [RULE_13]
      end
   end

   // flag: set wins over a write-one clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_r <= 1'b0;
      end else if (owd_overflow) begin
         irq_r <= 1'b1;                          // [RULE_12]
      end else if (wr_en && paddr == `CCS_OFS_STATUS && pwdata[`CCS_STAT_IRQ]) begin
         irq_r <= 1'b0;
      end
   end
   assign clock_fail_irq = irq_r;

   // ============================================================
   // multiplier: period measure and phase accumulator
   logic [PERIOD_W-1:0] per_cnt_r;
   logic [PERIOD_W-1:0] per_meas_r;
   logic [PERIOD_W-1:0] per_used_r;
   logic [PERIOD_W-1:0] acc_r;
   logic [PERIOD_W:0]   acc_sum;
   logic [3:0]          trans_cnt_r;
   logic                mult_toggle;
   logic                resync;

   // new period adopted on every F'th input transition
   assign resync = xin_edge && (trans_cnt_r + 4'h1 >= resync_trans);

   // input period in clk_sys cycles, saturating on a stopped input
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         per_cnt_r  <= '1;                       // first rise wraps to 0: no period yet
         per_meas_r <= '0;
      end else if (xin_rise) begin
         per_meas_r <= per_cnt_r + PERIOD_W'(1);
         per_cnt_r  <= '0;
      end else if (per_cnt_r != '1) begin
         per_cnt_r  <= per_cnt_r + PERIOD_W'(1);
      end
   end

   // new period adopted only every F transitions, keeping steps gentle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         trans_cnt_r <= 4'h0;
         per_used_r  <= '0;
      end else if (xin_edge) begin
         if (resync) begin
            trans_cnt_r <= 4'h0;
            per_used_r  <= per_meas_r;           // [RULE_06]
         end else begin
            trans_cnt_r <= trans_cnt_r + 4'h1;
         end
      end
   end

   // adds 2F per cycle; one toggle each time a period's worth builds up
   assign acc_sum     = {1'b0, acc_r} + {{(PERIOD_W-3){1'b0}}, toggles_per_period};
   assign mult_toggle = (per_used_r != '0) && (acc_sum >= {1'b0, per_used_r});

   always_ff @(posedge clk_sys) begin
      if (srst || path != ccs_pkg::CCS_PATH_MULT || per_used_r == '0) begin
         acc_r <= '0;                            // nothing builds up before a period is known
      end else if (resync && acc_sum >= {1'b0, per_meas_r}) begin
         acc_r <= '0;                            // [RULE_16] shorter period: restart, no burst
      end else if (mult_toggle) begin
         acc_r <= PERIOD_W'(acc_sum - {1'b0, per_used_r});   // [RULE_05]
      end else begin
         acc_r <= acc_sum[PERIOD_W-1:0];
      end
   end

   // ============================================================
   // source select and cpu clock
   ccs_pkg::ccs_src_t src_r;
   logic              cpu_clk_r;
   logic              cpu_clk_nxt;
   logic              loop_clk_r;

   // loop clock itself: toggles each loop tick
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         loop_clk_r <= 1'b0;
      end else if (loop_tick) begin
         loop_clk_r <= ~loop_clk_r;
      end
   end

   // switch only while the cpu clock is low, so no high phase is cut
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         src_r <= ccs_pkg::CCS_SRC_INPUT;
      end else begin
         case (src_r)
            ccs_pkg::CCS_SRC_INPUT: begin
               if (fail_r && !cpu_clk_r) begin
                  src_r <= ccs_pkg::CCS_SRC_LOOP;     // [RULE_16] [RULE_12]
               end
            end
            ccs_pkg::CCS_SRC_LOOP: begin
               src_r <= ccs_pkg::CCS_SRC_LOOP;        // [RULE_13]
            end
            default: begin
               src_r <= ccs_pkg::CCS_SRC_INPUT;
            end
         endcase
      end
   end

   always_comb begin
      cpu_clk_nxt = cpu_clk_r;
      if (src_r == ccs_pkg::CCS_SRC_LOOP) begin
         // holds until the next loop tick, then follows the loop clock, no runt pulse
         if (loop_tick) begin
            cpu_clk_nxt = ~loop_clk_r;
         end
      end else if (fail_r) begin
         cpu_clk_nxt = 1'b0;                     // [RULE_16]
      end else begin
         case (path)
            ccs_pkg::CCS_PATH_DIRECT: begin
               cpu_clk_nxt = xin_s2_r;           // [RULE_04]
            end
            ccs_pkg::CCS_PATH_PRESCALE: begin
               if (xin_rise) begin
                  cpu_clk_nxt = ~cpu_clk_r;      // [RULE_03]
               end
            end
            default: begin
               if (mult_toggle) begin
                  cpu_clk_nxt = ~cpu_clk_r;      // [RULE_05]
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cpu_clk_r <= 1'b0;
      end else begin
         cpu_clk_r <= cpu_clk_nxt;
      end
   end

   assign cpu_clk     = cpu_clk_r;
   assign cpu_on_loop = (src_r == ccs_pkg::CCS_SRC_LOOP);

endmodule : ccs_clock_select

// File: ccs_clock_select_props.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_clock_select_props #(
   parameter int PERIOD_W = 16,
   parameter int LOOP_DIV = 10
) (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        clock_input_pin,
   input wire logic [2:0]  clock_mode_strap_pins,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_clk,
   input wire logic        loop_enable,
   input wire logic        cpu_on_loop,
   input wire logic        clock_fail_irq
);
   // ====
   // shadow state
   logic [2:0]  mode_r;
   logic        dis_r;
   logic        fl_r;
   logic [2:0]  up_r;
   int unsigned stl_r;
   wire         dm    = mode_r == 3'h1 || mode_r == 3'h3;
   wire         wd_on = dm && !dis_r;

   // straps only count while reset holds them; stl_r is idle time of the pin
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode_r <= clock_mode_strap_pins;
         dis_r  <= 1'b0;
         fl_r   <= 1'b0;
         up_r   <= 3'h0;
         stl_r  <= 0;
      end else begin
         if (psel && penable && pwrite && paddr == `CCS_OFS_SYSCFG) begin
            dis_r <= pwdata[`CCS_SYSCFG_OWD_DIS];
         end
         fl_r  <= fl_r | clock_fail_irq;
         up_r  <= up_r + {2'h0, up_r != 3'h7};
         stl_r <= $changed(clock_input_pin) ? 0 : stl_r + 1;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // ====
   // properties
   sequence s_fail; $rose(clock_fail_irq); endsequence
   property p_loop_en; loop_enable == (!dm || !dis_r || fl_r || clock_fail_irq); endproperty
   a_loop_en: assert property (p_loop_en) else $error("loop enable wrong");
   property p_direct;
      mode_r == `CCS_CODE_DIRECT && up_r == 3'h7 && !fl_r && !clock_fail_irq && !cpu_on_loop
         |-> cpu_clk == $past(clock_input_pin, 3);
   endproperty
   a_direct: assert property (p_direct) else $error("direct clock wrong");
   property p_presc;
      mode_r == `CCS_CODE_PRESCALE && up_r == 3'h7 && !fl_r && $rose(clock_input_pin)
         |-> ##3 $changed(cpu_clk);
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler missed");
   property p_early; s_fail |-> stl_r >= 15 * LOOP_DIV; endproperty
   a_early: assert property (p_early) else $error("failure too early");
   property p_late; wd_on && stl_r == 16 * LOOP_DIV + 8 |-> fl_r || clock_fail_irq; endproperty
   a_late: assert property (p_late) else $error("failure missed");
   property p_switch; s_fail |-> ##[1:3] cpu_on_loop; endproperty
   a_switch: assert property (p_switch) else $error("no fallback");
   property p_sticky; cpu_on_loop |=> cpu_on_loop; endproperty
   a_sticky: assert property (p_sticky) else $error("fallback left");
   property p_glitch; $changed(cpu_clk) |=> $stable(cpu_clk); endproperty
   a_glitch: assert property (p_glitch) else $error("short cpu clock level");
endmodule : ccs_clock_select_props

bind ccs_clock_select ccs_clock_select_props #(.PERIOD_W(PERIOD_W), .LOOP_DIV(LOOP_DIV))
   i_ccs_clock_select_props (.clk_sys, .srst, .clock_input_pin, .clock_mode_strap_pins,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_clk,
   .loop_enable, .cpu_on_loop, .clock_fail_irq);

// File: ccs_clock_select_tb.sv
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_clock_select_tb;
   localparam int LD = 4;
   localparam int TOG8 [8] = '{20, 4, 12, 8, 40, 16, 24, 32};
   logic        clk_sys, srst, pin, run, psel, penable, pwrite, err, wd;
   logic        pready, pslverr, cpu_clk, loop_enable, cpu_on_loop, clock_fail_irq;
   logic [2:0]  strp;
   logic [7:0]  hp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          fails, compares, cyc, n, e;

   // ====
   // design and source; LD shortens the watchdog tick
   ccs_clock_select #(.LOOP_DIV(LD)) i_ccs_clock_select (.clk_sys, .srst,
      .clock_input_pin(pin), .clock_mode_strap_pins(strp), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_clk, .loop_enable, .cpu_on_loop,
      .clock_fail_irq);
   ccs_osc_model i_ccs_osc_model (.clk_sys, .run, .half(hp), .pin);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // hang guard, run needs about 7500 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         results();
      end
   end

   // ====
   // tasks
   task automatic results();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, ex, got);
      end
   endtask : chk

   function automatic logic [31:0] f_stat(input int c, input logic f, i, l);
      return {25'h0, l, i, f, 1'b0, 3'(c)};
   endfunction : f_stat

   // one transfer, released only after pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(what, ex, rd);
   endtask : rdchk

   task automatic rst(input int k);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (k) @(posedge clk_sys);
      srst <= 1'b0;
   endtask : rst

   // cpu clock level changes over four input periods
   task automatic count_tog(output int t);
      int   r;
      logic pp, cp;
      t = 0;
      r = 0;
      pp = pin;
      cp = cpu_clk;
      while (r < 5) begin
         @(posedge clk_sys);
         r += int'(pin && !pp);
         t += int'(r >= 1 && r <= 4 && cpu_clk !== cp);
         pp = pin;
         cp = cpu_clk;
      end
   endtask : count_tog

   // ====
   // main sequence
   initial begin
      {srst, run, psel, penable, pwrite} = 5'h18;
      paddr = 12'h000;
      pwdata = 32'h0;
      strp = 3'h7;
      hp = 8'h14;
      fails = 0;
      compares = 0;
      cyc = 0;
      n = $urandom(47995);
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      rdchk("syscfg", `CCS_OFS_SYSCFG, 32'h0);
      apb(1'b1, 12'h00C, $urandom);
      rdchk("unmapped", 12'h008, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      for (int c = 0; c < 8; c++) begin
         strp <= 3'(c);
         run  <= 1'b1;
         hp   <= 8'(20 + $urandom % 10);
         wd = (c == 1 || c == 3);
         rst(5);
         rdchk("status", `CCS_OFS_STATUS, f_stat(c, 0, 0, 1));
         strp <= 3'($urandom);
         repeat (400) @(posedge clk_sys);
         count_tog(n);
         e = TOG8[c];
         chk("toggles", 32'(e), 32'((n >= e - 1 && n <= e + 1) ? e : n));
         run <= 1'b0;
         repeat (16 * LD + 12) @(posedge clk_sys);
         chk("fail irq", {31'h0, wd}, {31'h0, clock_fail_irq});
         run <= 1'b1;
         repeat (200) @(posedge clk_sys);
         rdchk("status", `CCS_OFS_STATUS, f_stat(c, wd, wd, 1));
         if (wd) begin
            apb(1'b1, `CCS_OFS_STATUS, 32'h20);
            apb(1'b1, `CCS_OFS_SYSCFG, 32'h10);
            rdchk("irq clear", `CCS_OFS_STATUS, f_stat(c, 1, 0, 1));
         end
      end
      strp <= 3'h3;
      rst(5);
      apb(1'b1, `CCS_OFS_SYSCFG, $urandom | 32'h10);
      rdchk("syscfg", `CCS_OFS_SYSCFG, 32'h10);
      rdchk("loop off", `CCS_OFS_STATUS, f_stat(3, 0, 0, 0));
      run <= 1'b0;
      repeat (16 * LD + 12) @(posedge clk_sys);
      chk("no fail", 32'h0, {31'h0, clock_fail_irq | cpu_on_loop});
      apb(1'b1, `CCS_OFS_SYSCFG, 32'h0);
      repeat (16 * LD + 12) @(posedge clk_sys);
      chk("fail", 32'h1, {31'h0, clock_fail_irq});
      rst(3);
      chk("source back", 32'h0, {31'h0, cpu_on_loop});
      results();
   end
endmodule : ccs_clock_select_tb

// File: ccs_consts.svh
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ============================================================
// register map (byte addresses, one 32-bit word each)
`define CCS_OFS_SYSCFG      12'h000
`define CCS_OFS_STATUS      12'h004

// ============================================================
// field positions
`define CCS_SYSCFG_OWD_DIS  4
`define CCS_STAT_MODE_LO    0
`define CCS_STAT_MODE_HI    2
`define CCS_STAT_FAIL       4
`define CCS_STAT_IRQ        5
`define CCS_STAT_LOOP_EN    6

// ============================================================
// reset values
`define CCS_SYSCFG_RST      1'b0
`define CCS_MODE_RST        3'h7

// ============================================================
// strap codes and timing counts
`define CCS_CODE_PRESCALE   3'h1
`define CCS_CODE_DIRECT     3'h3
`define CCS_OWD_LIMIT       4'hF
`define CCS_CLK_SYS_MHZ     50
`define CCS_LOOP_MHZ        5
`define CCS_LOOP_DIV        (`CCS_CLK_SYS_MHZ / `CCS_LOOP_MHZ)

`endif

// File: ccs_osc_model.sv
`timescale 1ns/1ps
// ====
// input source: square wave; a stopped source freezes the pin like a dead crystal
module ccs_osc_model (
   input  wire logic       clk_sys,
   input  wire logic       run,
   input  wire logic [7:0] half,
   output logic            pin
);
   logic [7:0] cnt_r = 8'h00;

   initial pin = 1'b0;

   // toggle every half clk_sys cycles
   always @(posedge clk_sys) begin
      if (!run) begin
         cnt_r <= 8'h00;
      end else if (cnt_r >= half - 8'h01) begin
         cnt_r <= 8'h00;
         pin   <= ~pin;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule : ccs_osc_model

// File: ccs_pkg.sv
package ccs_pkg;

   // cpu clock source; gray order along input -> loop
   typedef enum logic [0:0] {
      CCS_SRC_INPUT = 1'b0,
      CCS_SRC_LOOP  = 1'b1
   } ccs_src_t;

   // clock generation path chosen by the straps
   typedef enum logic [1:0] {
      CCS_PATH_MULT     = 2'h0,
      CCS_PATH_DIRECT   = 2'h1,
      CCS_PATH_PRESCALE = 2'h3
   } ccs_path_t;

endpackage : ccs_pkg
